/* File: src/wdt_params.svh */
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH
// ********************************************************************
// Register map and access keys
// ********************************************************************
`define WDT_CNT_OFFSET  4'h0
`define WDT_CSR_OFFSET  4'h4
`define WDT_CNT_KEY     8'h5A
`define WDT_CSR_KEY     8'hA5
`define WDT_WORD_STRB   4'h3
`define WDT_CNT_RESET   8'h00
`define WDT_CSR_RESET   8'h00
`define WDT_CNT_MAX     8'hFF
`define WDT_REENTRY_PRE 8'h7F
// ********************************************************************
// Bus answers
// ********************************************************************
`define AXI_RESP_OKAY   2'h0
`define AXI_RESP_SLVERR 2'h2
`define AXI_RESP_DECERR 2'h3
// ********************************************************************
// Count clock division masks, one per select code
// ********************************************************************
`define WDT_DIV_MASK_0  12'h000
`define WDT_DIV_MASK_1  12'h003
`define WDT_DIV_MASK_2  12'h00F
`define WDT_DIV_MASK_3  12'h01F
`define WDT_DIV_MASK_4  12'h03F
`define WDT_DIV_MASK_5  12'h0FF
`define WDT_DIV_MASK_6  12'h3FF
`define WDT_DIV_MASK_7  12'hFFF
`define WDT_PRESCALE_W  12
// ********************************************************************
// Reset signalling
// ********************************************************************
`define WDT_MRST_CYCLES 3'h5
`endif

/* File: src/wdt_pkg.sv */
// ********************************************************************
// Shared types of the watchdog unit
// ********************************************************************
package wdt_pkg;

  // Layout of the control and status byte, most significant first.
  typedef struct packed {
    logic       run_enable_bit;
    logic       mode_select_bit;
    logic       reset_kind_bit;
    logic       watchdog_overflow_flag;
    logic       interval_overflow_flag;
    logic [2:0] count_clock_select;
  } csr_t;

  // Which job the counter is doing at the moment.
  typedef enum logic [2:0] {
    PH_NORMAL,
    PH_STANDBY_ENABLE_BIT_WAIT,
    PH_STANDBY_ENABLE_BIT_SETTLE,
    PH_STANDBY_ENABLE_BIT_RUN,
    PH_FREQ_SETTLE,
    PH_FREQ_TAIL
  } phase_t;

  // Requested reset pulse kinds.
  typedef struct packed {
    logic power_on;
    logic manual;
  } reset_fire_t;

endpackage

/* File: src/count_prescaler.sv */
`timescale 1ns/10ps
`default_nettype none
`include "wdt_params.svh"
// ********************************************************************
// Free running divider of the peripheral clock
// ********************************************************************
module count_prescaler (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [2:0] select,
  output logic            tick
);

  // Divider state; it never stops, so ratio changes take effect at once.
  logic [`WDT_PRESCALE_W-1:0] div;
  logic [`WDT_PRESCALE_W-1:0] next_div;

  // Maps a select code to the mask of divider bits that must be all ones.
  function automatic logic [`WDT_PRESCALE_W-1:0] div_mask(
    input logic [2:0] code);
    unique case (code)
      3'h0: div_mask = `WDT_DIV_MASK_0;
      3'h1: div_mask = `WDT_DIV_MASK_1;
      3'h2: div_mask = `WDT_DIV_MASK_2;
      3'h3: div_mask = `WDT_DIV_MASK_3;
      3'h4: div_mask = `WDT_DIV_MASK_4;
      3'h5: div_mask = `WDT_DIV_MASK_5;
      3'h6: div_mask = `WDT_DIV_MASK_6;
      3'h7: div_mask = `WDT_DIV_MASK_7;
    endcase
  endfunction

  // One enable pulse each time the masked low bits are all ones.
  assign tick = ((div & div_mask(select)) == div_mask(select));

  // Next divider value.
  always_comb begin
    next_div = div + `WDT_PRESCALE_W'(1);
  end

  // Divider register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div <= '0;
    end else begin
      div <= next_div;
    end
  end

endmodule
`default_nettype wire

/* File: src/reset_pulse_gen.sv */
`timescale 1ns/10ps
`default_nettype none
`include "wdt_params.svh"
// ********************************************************************
// Stretches a watchdog reset request onto the request and status pins
// ********************************************************************
module reset_pulse_gen (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire wdt_pkg::reset_fire_t fire,
  input  wire logic                 count_tick,
  output logic                      power_on_req,
  output logic                      manual_req,
  output logic                      status_output_low,
  output logic                      status_output_high
);

  logic       por_active;   // Power-on pulse in progress.
  logic       mrst_active;  // Manual pulse in progress.
  logic [2:0] mrst_left;    // Manual pulse cycles still to go.
  logic       next_por_active;
  logic       next_mrst_active;
  logic [2:0] next_mrst_left;

  // A power-on pulse lasts until the next count tick; a manual one
  // lasts a fixed number of peripheral clocks.
  always_comb begin
    next_por_active  = por_active;
    next_mrst_active = mrst_active;
    next_mrst_left   = mrst_left;
    if (por_active && count_tick) begin
      next_por_active = 1'b0;
    end
    if (mrst_active) begin
      next_mrst_left = mrst_left - 3'h1;
      if (mrst_left == 3'h1) begin
        next_mrst_active = 1'b0;
      end
    end
    if (fire.power_on) begin
      next_por_active = 1'b1;
    end
    if (fire.manual) begin
      next_mrst_active = 1'b1;
      next_mrst_left   = `WDT_MRST_CYCLES;
    end
  end

  // Pulse state and the registered pins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_active         <= 1'b0;
      mrst_active        <= 1'b0;
      mrst_left          <= 3'h0;
      power_on_req       <= 1'b0;
      manual_req         <= 1'b0;
      status_output_low  <= 1'b0;
      status_output_high <= 1'b0;
    end else begin
      por_active         <= next_por_active;
      mrst_active        <= next_mrst_active;
      mrst_left          <= next_mrst_left;
      power_on_req       <= next_por_active;
      manual_req         <= next_mrst_active;
      // Both status pins go high together for any watchdog reset.
      status_output_low  <= next_por_active | next_mrst_active;
      status_output_high <= next_por_active | next_mrst_active;
    end
  end

endmodule
`default_nettype wire

/* File: src/watchdog_unit.sv */
// Summary of operation
// - 8-bit counter counts; overflow resets or interrupts.
// - Only power-on reset clears counter and control.
// - Counter written by keyed halfword only.
// - Control written by keyed halfword only.
// - Control survives watchdog reset and settling.
// - Run-enable bit starts and holds counting.
// - Mode bit picks interval or watchdog.
// - Reset-kind bit picks power-on or manual.
// - Watchdog flag set only in watchdog mode.
// - Interval flag set only in interval mode.
// - Standby wake starts count; overflow resumes clocks.
// - After wake, count on; re-enter standby at 80h.
// - PLL change settles, resumes clocks, halts near zero.
// - Watchdog overflow sets flag, resets, keeps counting.
// - Status pins high during watchdog reset.
// - Interval overflow sets flag, interrupts, keeps counting.
// - Only PLL ratio change or standby wake starts settling count.
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_params.svh"
module watchdog_unit (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite register port.
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Standby and clock generator handshakes, same clock domain.
  input  wire logic        standby_entry,
  input  wire logic        wake_event,
  input  wire logic        standby_enable_bit,
  input  wire logic        pll_ratio_change,
  output logic             clock_resume,
  output logic             standby_reenter,
  // Interrupt and reset requests.
  output logic             interval_irq,
  output logic             power_on_reset_req,
  output logic             manual_reset_req,
  output logic             status_output_low,
  output logic             status_output_high
);

  // ******************************************************************
  // Declarations
  // ******************************************************************
  wdt_pkg::csr_t        csr;            // Control and status byte.
  wdt_pkg::csr_t        next_csr;
  logic [7:0]           cnt;            // The up-counter.
  logic [7:0]           next_cnt;
  wdt_pkg::phase_t      phase;          // Current counter job.
  wdt_pkg::phase_t      next_phase;
  logic                 tick;           // Count clock enable.
  logic                 count_en;       // Counter advances this cycle.
  logic                 wrap;           // Overflow event.
  wdt_pkg::reset_fire_t fire;           // Reset request to the stretcher.
  logic                 next_irq;
  logic                 next_resume;
  logic                 next_reenter;
  logic                 aw_full;        // Write address held.
  logic                 w_full;         // Write data held.
  logic [3:0]           aw_addr;
  logic [31:0]          w_data;
  logic [3:0]           w_strb;
  logic                 next_aw_full;
  logic                 next_w_full;
  logic [3:0]           next_aw_addr;
  logic [31:0]          next_w_data;
  logic [3:0]           next_w_strb;
  logic                 next_bvalid;
  logic [1:0]           next_bresp;
  logic                 next_rvalid;
  logic [1:0]           next_rresp;
  logic [31:0]          next_rdata;
  logic                 cnt_wr;         // Accepted counter write.
  logic                 csr_wr;         // Accepted control write.

  // ******************************************************************
  // Helper functions
  // ******************************************************************
  // A keyed write is exactly the low halfword with the key on top.
  function automatic logic keyed(input logic [3:0]  strb,
                                 input logic [31:0] data,
                                 input logic [7:0]  key);
    keyed = (strb == `WDT_WORD_STRB) && (data[15:8] == key);
  endfunction

  // Register byte offset from a byte address; unused bits must be zero.
  function automatic logic [3:0] reg_sel(input logic [31:0] addr);
    reg_sel = (addr[31:4] == 28'h0000000) ? addr[3:0] : 4'hF;
  endfunction

  // ******************************************************************
  // Count clock and reset pulse helpers
  // ******************************************************************
  count_prescaler u_prescaler (
    .aclk    (aclk),
    .aresetn (aresetn),
    .select  (csr.count_clock_select),
    .tick    (tick)
  );

  reset_pulse_gen u_pulse (
    .aclk               (aclk),
    .aresetn            (aresetn),
    .fire               (fire),
    .count_tick         (tick),
    .power_on_req       (power_on_reset_req),
    .manual_req         (manual_reset_req),
    .status_output_low  (status_output_low),
    .status_output_high (status_output_high)
  );

  // ******************************************************************
  // Counter, phase and events
  // ******************************************************************
  // The settling phases count whatever the run-enable bit says, since
  // software has to clear that bit before standby or a PLL change.
  always_comb begin
    unique case (phase)
      wdt_pkg::PH_NORMAL:    count_en = tick && csr.run_enable_bit;
      wdt_pkg::PH_STANDBY_ENABLE_BIT_WAIT: count_en = 1'b0;
      default:               count_en = tick;
    endcase
  end

  assign wrap = count_en && (cnt == `WDT_CNT_MAX);

  // Next counter, phase, flags and event pulses.
  always_comb begin
    next_cnt     = cnt;
    next_phase   = phase;
    next_csr     = csr;
    next_irq     = 1'b0;
    next_resume  = 1'b0;
    next_reenter = 1'b0;
    fire         = '0;
    if (count_en) begin
      next_cnt = cnt + 8'h01;
    end
    if (cnt_wr) begin
      next_cnt = w_data[7:0];
    end
    if (csr_wr) begin
      next_csr = wdt_pkg::csr_t'(w_data[7:0]);
    end
    unique case (phase)
      wdt_pkg::PH_NORMAL: begin
        if (wrap && csr.mode_select_bit) begin
          // Watchdog overflow: flag and reset, counting goes on.
          next_csr.watchdog_overflow_flag = 1'b1;
          fire.power_on = !csr.reset_kind_bit;
          fire.manual   = csr.reset_kind_bit;
        end else if (wrap) begin
          // Interval overflow: flag and interrupt, counting goes on.
          next_csr.interval_overflow_flag = 1'b1;
          next_irq = 1'b1;
        end
        if (standby_entry) begin
          next_phase = wdt_pkg::PH_STANDBY_ENABLE_BIT_WAIT;
        end else if (pll_ratio_change) begin
          next_phase = wdt_pkg::PH_FREQ_SETTLE;
        end
      end
      wdt_pkg::PH_STANDBY_ENABLE_BIT_WAIT: begin
        if (wake_event) begin
          next_phase = wdt_pkg::PH_STANDBY_ENABLE_BIT_SETTLE;
        end
      end
      wdt_pkg::PH_STANDBY_ENABLE_BIT_SETTLE: begin
        // No flag is touched here, so the control byte survives.
        if (wrap) begin
          next_resume = 1'b1;
          next_phase  = wdt_pkg::PH_STANDBY_ENABLE_BIT_RUN;
        end
      end
      wdt_pkg::PH_STANDBY_ENABLE_BIT_RUN: begin
        if (!standby_enable_bit) begin
          next_phase = wdt_pkg::PH_NORMAL;
        end else if (count_en && cnt == `WDT_REENTRY_PRE) begin
          next_reenter = 1'b1;
          next_phase   = wdt_pkg::PH_STANDBY_ENABLE_BIT_WAIT;
        end
      end
      wdt_pkg::PH_FREQ_SETTLE: begin
        // At the undivided ratio one more tick lands before the halt.
        if (wrap) begin
          next_resume = 1'b1;
          next_phase  = (csr.count_clock_select == 3'h0)
                        ? wdt_pkg::PH_FREQ_TAIL : wdt_pkg::PH_NORMAL;
        end
      end
      wdt_pkg::PH_FREQ_TAIL: begin
        if (count_en) begin
          next_phase = wdt_pkg::PH_NORMAL;
        end
      end
    endcase
  end

  // Counter state; cleared only by the power-on reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt             <= `WDT_CNT_RESET;
      csr             <= wdt_pkg::csr_t'(`WDT_CSR_RESET);
      phase           <= wdt_pkg::PH_NORMAL;
      interval_irq    <= 1'b0;
      clock_resume    <= 1'b0;
      standby_reenter <= 1'b0;
    end else begin
      cnt             <= next_cnt;
      csr             <= next_csr;
      phase           <= next_phase;
      interval_irq    <= next_irq;
      clock_resume    <= next_resume;
      standby_reenter <= next_reenter;
    end
  end

  // ******************************************************************
  // AXI4-Lite slave
  // ******************************************************************
  // Address and data are taken independently; the write is done in
  // the cycle both are held and no response is pending. A write that
  // is misshapen or carries the wrong key changes nothing.
  always_comb begin
    next_aw_full = aw_full;
    next_w_full  = w_full;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    cnt_wr       = 1'b0;
    csr_wr       = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_full = 1'b1;
      next_aw_addr = reg_sel(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_full && w_full && !s_axi_bvalid) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = `AXI_RESP_SLVERR;
      if (aw_addr == `WDT_CNT_OFFSET) begin
        if (keyed(w_strb, w_data, `WDT_CNT_KEY)) begin
          cnt_wr     = 1'b1;
          next_bresp = `AXI_RESP_OKAY;
        end
      end else if (aw_addr == `WDT_CSR_OFFSET) begin
        if (keyed(w_strb, w_data, `WDT_CSR_KEY)) begin
          csr_wr     = 1'b1;
          next_bresp = `AXI_RESP_OKAY;
        end
      end else begin
        next_bresp = `AXI_RESP_DECERR;
      end
    end
  end

  // Read side: one read at a time, byte value in the low lane.
  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rresp  = s_axi_rresp;
    next_rdata  = s_axi_rdata;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = `AXI_RESP_OKAY;
      unique case (reg_sel(s_axi_araddr))
        `WDT_CNT_OFFSET: next_rdata = {24'h000000, cnt};
        `WDT_CSR_OFFSET: next_rdata = {24'h000000, csr};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = `AXI_RESP_DECERR;
        end
      endcase
    end
  end

  // Bus registers; ready flags drop while something is held.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_addr       <= 4'h0;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `AXI_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `AXI_RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
    end else begin
      aw_full       <= next_aw_full;
      w_full        <= next_w_full;
      aw_addr       <= next_aw_addr;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      s_axi_awready <= !next_aw_full && !next_bvalid;
      s_axi_wready  <= !next_w_full && !next_bvalid;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= !next_rvalid && !(s_axi_arvalid && s_axi_arready);
      s_axi_rvalid  <= next_rvalid;
      s_axi_rresp   <= next_rresp;
      s_axi_rdata   <= next_rdata;
    end
  end

endmodule
`default_nettype wire

/* File: tb/wdt_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module wdt_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        interval_irq,
  input wire logic        power_on_reset_req,
  input wire logic        manual_reset_req,
  input wire logic        status_output_low,
  input wire logic        status_output_high,
  input wire logic        clock_resume,
  input wire logic        standby_reenter
);
  // ******
  // Port checks, all in the single clock domain
  // ******
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_irq_pulse: assert property (interval_irq |=> !interval_irq)
    else $error("interval request longer than one cycle");
  chk_resume_pulse: assert property (clock_resume |=> !clock_resume)
    else $error("clock resume longer than one cycle");
  chk_reenter_pulse: assert property (
    standby_reenter |=> !standby_reenter)
    else $error("standby re-entry longer than one cycle");
  chk_mrst_width: assert property ($rose(manual_reset_req) |->
    manual_reset_req[*5] ##1 !manual_reset_req)
    else $error("manual reset request not five cycles");
  chk_status_pins: assert property (
    $rose(manual_reset_req || power_on_reset_req) |->
    ##[0:1] (status_output_low && status_output_high))
    else $error("status pins not high during reset");
  chk_reset_kind: assert property (
    power_on_reset_req |-> !manual_reset_req)
    else $error("both reset kinds requested");
  chk_rd_byte: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data wider than a byte");
  chk_reset_quiet: assert property ($rose(aresetn) |->
    !interval_irq && !power_on_reset_req && !manual_reset_req)
    else $error("request active right after reset");
  // Main scenarios are reached.
  cov_irq: cover property (interval_irq);
  cov_mrst: cover property ($rose(manual_reset_req));
  cov_reenter: cover property (standby_reenter);
endmodule
bind watchdog_unit wdt_asserts u_wdt_asserts (.aclk(aclk),
  .aresetn(aresetn), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rdata(s_axi_rdata), .interval_irq(interval_irq),
  .power_on_reset_req(power_on_reset_req),
  .manual_reset_req(manual_reset_req), .clock_resume(clock_resume),
  .status_output_low(status_output_low), .standby_reenter(standby_reenter),
  .status_output_high(status_output_high));
`default_nettype wire

/* File: tb/cpg_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ******
// Clock generator and standby control seen by the watchdog unit
// ******
module cpg_model (
  input  wire logic aclk,
  output logic      standby_entry,
  output logic      wake_event,
  output logic      pll_ratio_change,
  output logic      standby_enable_bit
);
  // Pulses start idle so nothing fires before software asks.
  initial begin
    {standby_entry, wake_event, pll_ratio_change, standby_enable_bit} = 4'h0;
  end
  // Standby entry with the enable bit driven from en, so re-entry is armed when en is 1.
  task automatic enter_standby(input logic en);
    standby_enable_bit <= en;
    standby_entry <= 1'b1;
    @(posedge aclk);
    standby_entry <= 1'b0;
  endtask
  // Interrupt edge during standby starts the settling count.
  task automatic wake();
    wake_event <= 1'b1;
    @(posedge aclk);
    wake_event <= 1'b0;
  endtask
  // Pulsed only for a multiplier change, never for divider changes.
  task automatic pll_change();
    pll_ratio_change <= 1'b1;
    @(posedge aclk);
    pll_ratio_change <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "wdt_params.svh"
module tb_top;
  // ******
  // Signals
  // ******
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, clock_resume;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        standby_entry, wake_event, standby_enable_bit, irq;
  logic        pll_ratio_change, standby_reenter, por_req, mrst_req;
  logic        status_output_low, status_output_high;
  int          num_errors, checks_done, n, irq_cnt, irq0;
  localparam logic [31:0] CNT = {28'h0, `WDT_CNT_OFFSET};
  localparam logic [31:0] CSR = {28'h0, `WDT_CSR_OFFSET};
  watchdog_unit u_watchdog_unit (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .standby_entry(standby_entry),
    .wake_event(wake_event), .standby_enable_bit(standby_enable_bit),
    .pll_ratio_change(pll_ratio_change), .clock_resume(clock_resume),
    .standby_reenter(standby_reenter), .interval_irq(irq),
    .power_on_reset_req(por_req), .manual_reset_req(mrst_req),
    .status_output_low(status_output_low),
    .status_output_high(status_output_high));
  cpg_model u_cpg_model (.aclk(aclk), .standby_entry(standby_entry),
    .wake_event(wake_event), .pll_ratio_change(pll_ratio_change),
    .standby_enable_bit(standby_enable_bit));
  // ******
  // Tasks
  // ******
  task automatic chk(input string nm, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Address and data go out together; each drops once taken.
  task automatic wr(input logic [31:0] a, input logic [31:0] v,
                    input logic [3:0] s);
    logic aw, w;
    {aw, w} = 2'h3;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [31:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
  endtask
  // Keyed halfword write expected to be accepted.
  task automatic kw(input logic [31:0] a, input logic [7:0] v);
    wr(a, {16'h0, (a == CNT) ? `WDT_CNT_KEY : `WDT_CSR_KEY, v}, 4'h3);
    chk("wresp", {30'h0, r}, {30'h0, `AXI_RESP_OKAY});
  endtask
  // Waits a bounded time for one of the event outputs.
  task automatic wt(input int k);
    n = 0;
    while (!(k == 0 ? irq : k == 1 ? mrst_req : k == 2 ? por_req :
             k == 3 ? clock_resume : standby_reenter) && n < 20000) begin
      @(posedge aclk);
      n++;
    end
    chk("event", n < 20000, 1);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ******
  // Clock, watchdog and tests
  // ******
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) if (irq) irq_cnt++;
  initial begin
    repeat (60000) @(posedge aclk);
    num_errors++;
    end_sim();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(CNT); chk("cnt", d, 32'h00);
    rd(CSR); chk("csr", d, 32'h00);
    // Wrong key, byte strobe, bad place: nothing changes.
    wr(CNT, 32'h0000A5F0, 4'h3); chk("bresp", r, 2'h2);
    wr(CNT, 32'h00005AF0, 4'h1); chk("bresp", r, 2'h2);
    wr(CSR, 32'h00005A80, 4'h3); chk("bresp", r, 2'h2);
    wr(32'h8, 32'h00005A80, 4'h3); chk("bresp", r, 2'h3);
    rd(32'h8); chk("rresp", s_axi_rresp, 2'h3);
    rd(CNT); chk("cnt", d, 32'h00);
    kw(CNT, 8'hF0);
    repeat (50) @(posedge aclk);
    rd(CNT); chk("cnt", d, 32'hF0);
    // Interval mode at the four fastest ratios; one pulse per wrap.
    for (int k = 0; k < 4; k++) begin
      kw(CNT, 8'hF0);
      kw(CSR, 8'h80 | k[7:0]);
      wt(0);
      n = 0;
      do begin @(posedge aclk); n++; end while (!irq && n < 9000);
      chk("gap", n, 256 << (k == 3 ? 5 : 2 * k));
      rd(CSR); chk("csr", d, 32'h88 | k);
      kw(CSR, 8'h00);
    end
    // Watchdog mode, manual then power-on kind; interval stays quiet.
    irq0 = irq_cnt;
    kw(CNT, 8'hF0);
    kw(CSR, 8'hE0);
    repeat (3) kw(CNT, 8'h00);
    rd(CSR); chk("csr", d, 32'hE0);
    wt(1);
    rd(CSR); chk("csr", d, 32'hF0);
    kw(CSR, 8'h00);
    kw(CNT, 8'hF0);
    kw(CSR, 8'hC0);
    wt(2);
    rd(CSR); chk("csr", d, 32'hD0);
    chk("irqs", irq_cnt, irq0);
    kw(CSR, 8'h00);
    // Multiplier change settles at /4 and halts at zero.
    kw(CNT, 8'hF0);
    kw(CSR, 8'h01);
    u_cpg_model.pll_change();
    wt(3);
    repeat (20) @(posedge aclk);
    rd(CNT); chk("cnt", d, 32'h00);
    rd(CSR); chk("csr", d, 32'h01);
    // Standby wake, resume, then re-entry at the halfway count.
    kw(CSR, 8'h00);
    kw(CNT, 8'hF0);
    u_cpg_model.pll_change();
    wt(3);
    rd(CNT); chk("cnt", d, 32'h01);
    kw(CNT, 8'hF0);
    u_cpg_model.enter_standby(1'b1);
    repeat (10) @(posedge aclk);
    rd(CNT); chk("cnt", d, 32'hF0);
    u_cpg_model.wake();
    wt(3);
    rd(CSR); chk("csr", d, 32'h00);
    wt(4);
    repeat (3) @(posedge aclk);
    rd(CNT); chk("cnt", d, 32'h80);
    end_sim();
  end
endmodule
`default_nettype wire
